// ===== tb/colour_timing_model.sv
`timescale 1ns/100ps
module colour_timing_model (
  input wire logic clk,
  input wire led_mode_pkg::colour_en_s want,
  output led_mode_pkg::colour_en_s colour_en
);
  // Enables change only just after a clock edge
  always_ff @(posedge clk) begin
    colour_en <= want;
  end
endmodule

// ===== tb/led_mode_monitor.sv
`timescale 1ns/100ps
module led_mode_monitor (
  input wire logic clk,
  input wire logic rst,
  input wire logic por,
  input wire logic global_en,
  input wire led_mode_pkg::colour_en_s colour_en,
  input wire logic over_temperature_trip,
  input wire logic cfg_we,
  input wire led_mode_pkg::iset_s cfg_iset,
  input wire logic nvm_busy,
  input wire led_mode_pkg::mode_e mode,
  input wire logic support_on,
  input wire logic converter_on,
  input wire logic converter_low_current,
  input wire led_mode_pkg::colour_en_s driver_on,
  input wire led_mode_pkg::iset_s iset
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  por_shut_a: assert property (por [*3] |->
    mode == led_mode_pkg::MODE_SHUTDOWN && !support_on) else
    $error("power-on reset did not force shutdown");
  shut_idle_a: assert property (mode == led_mode_pkg::MODE_SHUTDOWN |->
    !converter_on && driver_on == 3'h0) else $error("active in shutdown");
  stby_off_a: assert property (mode == led_mode_pkg::MODE_STANDBY |->
    support_on && !converter_on && driver_on == 3'h0) else
    $error("converter or driver on in standby");
  stby_hold_a: assert property ((mode == led_mode_pkg::MODE_STANDBY &&
    colour_en == 3'h0 && global_en && !por) [*6] |=>
    mode == led_mode_pkg::MODE_STANDBY) else $error("standby left without enable");
  soft_low_a: assert property (mode == led_mode_pkg::MODE_SOFT_START |->
    converter_on && converter_low_current) else $error("soft start not low current");
  norm_on_a: assert property (mode == led_mode_pkg::MODE_NORMAL |->
    converter_on && !converter_low_current) else $error("normal mode outputs wrong");
  cfg_now_a: assert property (cfg_we && !nvm_busy &&
    mode == led_mode_pkg::MODE_STANDBY |=> iset == $past(cfg_iset)) else
    $error("standby write not applied");
  temp_stop_a: assert property (over_temperature_trip [*3] |->
    !converter_on && driver_on == 3'h0) else $error("running while over temperature");
  one_drv_a: assert property ($onehot0(driver_on)) else
    $error("more than one driver on");
endmodule
bind sequential_led_mode_controller led_mode_monitor u_led_mode_monitor (.clk,
  .rst, .por, .global_en, .colour_en, .over_temperature_trip, .cfg_we,
  .cfg_iset, .nvm_busy, .mode, .support_on, .converter_on,
  .converter_low_current, .driver_on, .iset);

// ===== tb/test_sequential_led_mode_controller.sv
`timescale 1ns/100ps
`include "led_mode_cfg.svh"
module test_sequential_led_mode_controller;
  logic clk, rst, por, global_en, otp, cfg_we;
  led_mode_pkg::colour_en_s want, colour_en, driver_on;
  led_mode_pkg::iset_s cfg_iset, iset;
  logic [`SS_SEL_W-1:0] cfg_ss, ss_sel;
  logic [`TO_SEL_W-1:0] cfg_to, to_sel;
  led_mode_pkg::mode_e mode;
  logic support_on, converter_on, low_cur, nvm_busy, nvm_ready, nvm_req;
  int err_count = 0;
  int check_count = 0;
  int n;
  colour_timing_model u_colour_timing_model (.clk(clk), .want(want),
    .colour_en(colour_en));
  sequential_led_mode_controller u_sequential_led_mode_controller (
    .clk(clk), .rst(rst), .por(por), .global_en(global_en),
    .colour_en(colour_en), .over_temperature_trip(otp), .cfg_we(cfg_we),
    .cfg_iset(cfg_iset), .cfg_soft_start(cfg_ss), .cfg_timeout(cfg_to),
    .nvm_prog_req(nvm_req), .mode(mode), .support_on(support_on),
    .converter_on(converter_on), .converter_low_current(low_cur),
    .driver_on(driver_on), .iset(iset), .soft_start_sel(ss_sel),
    .timeout_sel(to_sel), .nvm_busy(nvm_busy), .nvm_ready(nvm_ready));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task summarize;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task cyc(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task wait_mode(input led_mode_pkg::mode_e m, input int lim);
    #1;
    n = 0;
    while (mode !== m && n < lim) begin
      cyc(1);
      n++;
    end
    chk(mode, m);
    if (mode !== m) summarize();
  endtask
  task set_want(input logic [2:0] w);
    @(posedge clk) want <= w;
    cyc(10);
  endtask
  task t_shutdown;
    chk(mode, led_mode_pkg::MODE_SHUTDOWN);
    @(posedge clk) rst <= 1'b0;
    cyc(20);
    chk(mode, led_mode_pkg::MODE_SHUTDOWN);
    chk(support_on, 1'b0);
    $display("shutdown test done");
  endtask
  task t_startup;
    @(posedge clk) global_en <= 1'b1;
    wait_mode(led_mode_pkg::MODE_STANDBY, 400);
    chk(n >= `STARTUP_CYCLES, 1'b1);
    chk({support_on, converter_on, driver_on}, 5'h10);
    $display("startup test done");
  endtask
  task t_config;
    @(posedge clk) begin
      cfg_we <= 1'b1;
      cfg_iset <= {10'h2AA, 10'h155, 10'h3FF};
      cfg_ss <= 4'h1;
      cfg_to <= 8'h00;
    end
    @(posedge clk) cfg_we <= 1'b0;
    #1;
    chk(iset, {10'h2AA, 10'h155, 10'h3FF});
    chk({ss_sel, to_sel}, 12'h100);
    $display("config test done");
  endtask
  task t_nvm;
    @(posedge clk) nvm_req <= 1'b1;
    @(posedge clk) nvm_req <= 1'b0;
    cyc(8);
    chk({nvm_busy, nvm_ready}, 2'h2);
    @(posedge clk) global_en <= 1'b0;
    wait_mode(led_mode_pkg::MODE_SHUTDOWN, 10);
    @(posedge clk) global_en <= 1'b1;
    wait_mode(led_mode_pkg::MODE_STANDBY, 400);
    chk(iset, {10'h2AA, 10'h155, 10'h3FF});
    chk({ss_sel, to_sel}, 12'h100);
    chk({nvm_busy, nvm_ready}, 2'h0);
    $display("nvm test done");
  endtask
  task t_sequence;
    set_want(3'h4);
    chk(mode, led_mode_pkg::MODE_SOFT_START);
    chk(low_cur, 1'b1);
    wait_mode(led_mode_pkg::MODE_NORMAL, 2 * `SS_CYCLES_PER_STEP + 50);
    chk(n + 20 > 2 * `SS_CYCLES_PER_STEP - 20, 1'b1);
    cyc(10);
    chk(driver_on, 3'h4);
    set_want(3'h6);
    chk(driver_on, 3'h4);
    set_want(3'h2);
    chk(driver_on, 3'h2);
    set_want(3'h7);
    chk(driver_on, 3'h2);
    set_want(3'h5);
    chk(driver_on, 3'h4);
    set_want(3'h1);
    chk(driver_on, 3'h1);
    set_want(3'h0);
    wait_mode(led_mode_pkg::MODE_STANDBY, `TO_CYCLES_PER_STEP + 50);
    chk(n + 20 > `TO_CYCLES_PER_STEP - 20, 1'b1);
    $display("sequence test done");
  endtask
  task t_faults;
    set_want(3'h4);
    wait_mode(led_mode_pkg::MODE_NORMAL, 2 * `SS_CYCLES_PER_STEP + 50);
    @(posedge clk) otp <= 1'b1;
    wait_mode(led_mode_pkg::MODE_STANDBY, 10);
    cyc(30);
    chk({mode, driver_on}, {led_mode_pkg::MODE_STANDBY, 3'h0});
    @(posedge clk) otp <= 1'b0;
    wait_mode(led_mode_pkg::MODE_SOFT_START, 20);
    @(posedge clk) nvm_req <= 1'b1;
    cyc(3);
    chk(nvm_busy, 1'b0);
    @(posedge clk) begin
      por <= 1'b1;
      nvm_req <= 1'b0;
    end
    wait_mode(led_mode_pkg::MODE_SHUTDOWN, 10);
    chk({support_on, converter_on}, 2'h0);
    @(posedge clk) por <= 1'b0;
    wait_mode(led_mode_pkg::MODE_STANDBY, 400);
    @(posedge clk) global_en <= 1'b0;
    wait_mode(led_mode_pkg::MODE_SHUTDOWN, 10);
    $display("fault test done");
  endtask
  initial begin
    rst = 1'b1;
    por = 1'b0;
    global_en = 1'b0;
    otp = 1'b0;
    cfg_we = 1'b0;
    nvm_req = 1'b0;
    want = 3'h0;
    cfg_iset = 30'h0;
    cfg_ss = 4'h0;
    cfg_to = 8'h0;
    cyc(16);
    t_shutdown();
    t_startup();
    t_config();
    t_nvm();
    t_sequence();
    t_faults();
    summarize();
  end
endmodule

// ===== verilog/led_mode_cfg.svh
`ifndef LED_MODE_CFG_SVH
`define LED_MODE_CFG_SVH

// ----------------------------------------
// Timing and sizes
// ----------------------------------------
`define CLK_PERIOD_NS 5
`define STARTUP_TIME_NS 1000
`define STARTUP_CYCLES ((`STARTUP_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SS_TIME_US_PER_STEP 10
`define SS_CYCLES_PER_STEP ((`SS_TIME_US_PER_STEP * 1000) / `CLK_PERIOD_NS)
`define TO_TIME_US_PER_STEP 10
`define TO_CYCLES_PER_STEP ((`TO_TIME_US_PER_STEP * 1000) / `CLK_PERIOD_NS)
`define NVM_WORDS 10
`define NVM_AW 4
`define ISET_W 10
`define SS_SEL_W 4
`define TO_SEL_W 8
`define CNT_W 24
`define NVM_PROG_TIME_MS 200
`define NVM_PROG_CYCLES ((`NVM_PROG_TIME_MS * 1000000) / `CLK_PERIOD_NS)

`endif

// ===== verilog/led_mode_pkg.sv
package led_mode_pkg;

  typedef enum logic [2:0] {
    MODE_SHUTDOWN,
    MODE_STARTUP,
    MODE_STANDBY,
    MODE_SOFT_START,
    MODE_NORMAL
  } mode_e;

  typedef enum logic [1:0] {
    CH_NONE,
    CH_RED,
    CH_GREEN,
    CH_BLUE
  } chan_e;

  typedef struct packed {
    logic red;
    logic green;
    logic blue;
  } colour_en_s;

  typedef struct packed {
    logic [9:0] red;
    logic [9:0] green;
    logic [9:0] blue;
  } iset_s;

endpackage

// ===== verilog/nvm_store.sv
`timescale 1ns/100ps
`include "led_mode_cfg.svh"

module nvm_store (
  input wire logic clk,
  input wire logic we,
  input wire logic [`NVM_AW-1:0] waddr,
  input wire logic [9:0] wdata,
  input wire logic [`NVM_AW-1:0] raddr,
  output logic [9:0] rdata
);

  // ----------------------------------------
  // Stored words, registered read
  // ----------------------------------------
  logic [9:0] mem [0:`NVM_WORDS-1];

  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge clk) begin
    rdata <= mem[raddr];
  end

endmodule

// ===== verilog/sequential_led_mode_controller.sv
`timescale 1ns/100ps
`include "led_mode_cfg.svh"

// What this block does
// - Global enable low or power-on reset forces and holds shutdown.
// - Power-on reset asserted at power-up and on low supply.
// - In shutdown all internal functions are disabled.
// - Enable high runs startup: reference, oscillator up, stored values loaded.
// - After startup enter standby: support on, converter and drivers off.
// - Standby accepts register writes, effective immediately.
// - Nonvolatile programming allowed only in standby.
// - Standby goes to soft start while any colour enable is high, over-temperature is clear and no NVM programming runs.
// - Soft start ramps converter in reduced current for programmed time.
// - Soft-start duration is software programmable.
// - Normal mode: converter and drivers active, timing by colour enables.
// - All colour enables low for timeout period returns to standby.
// - Over-temperature stops operation, holds standby until it clears.
// - At most one driver conducts at any instant.
// - Driver currents from registers, storable in nonvolatile memory.
// - Second colour waits until the active colour enable falls.
// - On release with several requests, pick red, then green, then blue.

module sequential_led_mode_controller (
  input wire logic clk,
  input wire logic rst,
  input wire logic por,
  input wire logic global_en,
  input wire led_mode_pkg::colour_en_s colour_en,
  input wire logic over_temperature_trip,
  input wire logic cfg_we,
  input wire led_mode_pkg::iset_s cfg_iset,
  input wire logic [`SS_SEL_W-1:0] cfg_soft_start,
  input wire logic [`TO_SEL_W-1:0] cfg_timeout,
  input wire logic nvm_prog_req,
  output led_mode_pkg::mode_e mode,
  output logic support_on,
  output logic converter_on,
  output logic converter_low_current,
  output led_mode_pkg::colour_en_s driver_on,
  output led_mode_pkg::iset_s iset,
  output logic [`SS_SEL_W-1:0] soft_start_sel,
  output logic [`TO_SEL_W-1:0] timeout_sel,
  output logic nvm_busy,
  output logic nvm_ready
);

  // ----------------------------------------
  // Functions
  // ----------------------------------------
  function automatic led_mode_pkg::chan_e pick(
    input led_mode_pkg::colour_en_s en);
    if (en.red) begin
      pick = led_mode_pkg::CH_RED;
    end else if (en.green) begin
      pick = led_mode_pkg::CH_GREEN;
    end else if (en.blue) begin
      pick = led_mode_pkg::CH_BLUE;
    end else begin
      pick = led_mode_pkg::CH_NONE;
    end
  endfunction

  function automatic logic still_on(input led_mode_pkg::chan_e c,
    input led_mode_pkg::colour_en_s en);
    case (c)
      led_mode_pkg::CH_RED: still_on = en.red;
      led_mode_pkg::CH_GREEN: still_on = en.green;
      led_mode_pkg::CH_BLUE: still_on = en.blue;
      default: still_on = 1'b0;
    endcase
  endfunction

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  logic [3:0] sync1_q;
  logic [3:0] sync2_q;
  logic g_en;
  led_mode_pkg::colour_en_s c_en;
  logic any_en;
  logic off_req;

  always_ff @(posedge clk) begin
    if (rst) begin
      sync1_q <= 4'h0;
      sync2_q <= 4'h0;
    end else begin
      sync1_q <= {global_en, colour_en};
      sync2_q <= sync1_q;
    end
  end

  assign g_en = sync2_q[3];
  assign c_en = sync2_q[2:0];
  assign any_en = |sync2_q[2:0];
  assign off_req = rst | por | ~g_en;

  // ----------------------------------------
  // Mode state machine
  // ----------------------------------------
  localparam int STARTUP_N = `STARTUP_CYCLES;
  localparam int SS_STEP_N = `SS_CYCLES_PER_STEP;
  localparam int TO_STEP_N = `TO_CYCLES_PER_STEP;

  led_mode_pkg::mode_e mode_q;
  logic [`CNT_W-1:0] cnt_q;
  logic load_done_q;
  logic [`NVM_AW-1:0] load_idx_q;

  always_ff @(posedge clk) begin
    if (off_req) begin
      mode_q <= led_mode_pkg::MODE_SHUTDOWN;
      cnt_q <= '0;
    end else begin
      case (mode_q)
        led_mode_pkg::MODE_SHUTDOWN: begin
          mode_q <= led_mode_pkg::MODE_STARTUP;
          cnt_q <= '0;
        end
        led_mode_pkg::MODE_STARTUP: begin
          if (cnt_q < `CNT_W'(STARTUP_N)) begin
            cnt_q <= cnt_q + 1'b1;
          end else if (load_done_q) begin
            mode_q <= led_mode_pkg::MODE_STANDBY;
            cnt_q <= '0;
          end
        end
        led_mode_pkg::MODE_STANDBY: begin
          cnt_q <= '0;
          if (any_en && !over_temperature_trip && !nvm_busy) begin
            mode_q <= led_mode_pkg::MODE_SOFT_START;
          end
        end
        led_mode_pkg::MODE_SOFT_START: begin
          if (over_temperature_trip) begin
            mode_q <= led_mode_pkg::MODE_STANDBY;
            cnt_q <= '0;
          end else if (cnt_q >= `CNT_W'(SS_STEP_N) *
                       `CNT_W'({1'b0, soft_start_sel} + 1'b1)) begin
            mode_q <= led_mode_pkg::MODE_NORMAL;
            cnt_q <= '0;
          end else begin
            cnt_q <= cnt_q + 1'b1;
          end
        end
        led_mode_pkg::MODE_NORMAL: begin
          if (over_temperature_trip) begin
            mode_q <= led_mode_pkg::MODE_STANDBY;
            cnt_q <= '0;
          end else if (any_en) begin
            cnt_q <= '0;
          end else if (cnt_q >= `CNT_W'(TO_STEP_N) *
                       `CNT_W'({1'b0, timeout_sel} + 1'b1)) begin
            mode_q <= led_mode_pkg::MODE_STANDBY;
            cnt_q <= '0;
          end else begin
            cnt_q <= cnt_q + 1'b1;
          end
        end
        default: begin
          mode_q <= led_mode_pkg::MODE_SHUTDOWN;
          cnt_q <= '0;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Channel arbiter
  // ----------------------------------------
  led_mode_pkg::chan_e chan_q;

  always_ff @(posedge clk) begin
    if (off_req || mode_q != led_mode_pkg::MODE_NORMAL ||
        over_temperature_trip) begin
      chan_q <= led_mode_pkg::CH_NONE;
    end else if (!still_on(chan_q, c_en)) begin
      chan_q <= pick(c_en);
    end
  end

  // ----------------------------------------
  // Configuration and nonvolatile store
  // ----------------------------------------
  logic nvm_we;
  logic [`NVM_AW-1:0] nvm_waddr;
  logic [9:0] nvm_wdata;
  logic [9:0] nvm_rdata;
  logic [`CNT_W+4:0] prog_cnt_q;
  logic [`NVM_AW-1:0] prog_idx_q;
  logic in_standby;

  assign in_standby = mode_q == led_mode_pkg::MODE_STANDBY;

  nvm_store u_nvm (
    .clk(clk),
    .we(nvm_we),
    .waddr(nvm_waddr),
    .wdata(nvm_wdata),
    .raddr(load_idx_q),
    .rdata(nvm_rdata)
  );

  always_comb begin
    nvm_we = nvm_busy && prog_idx_q < 4'h5;
    nvm_waddr = prog_idx_q;
    case (prog_idx_q)
      4'h0: nvm_wdata = iset.red;
      4'h1: nvm_wdata = iset.green;
      4'h2: nvm_wdata = iset.blue;
      4'h3: nvm_wdata = {6'h00, soft_start_sel};
      4'h4: nvm_wdata = {2'h0, timeout_sel};
      default: nvm_wdata = 10'h000;
    endcase
  end

  // Program sequence, standby only
  always_ff @(posedge clk) begin
    if (off_req) begin
      nvm_busy <= 1'b0;
      nvm_ready <= 1'b0;
      prog_idx_q <= 4'h0;
      prog_cnt_q <= '0;
    end else if (!nvm_busy) begin
      if (nvm_prog_req && in_standby) begin
        nvm_busy <= 1'b1;
        nvm_ready <= 1'b0;
        prog_idx_q <= 4'h0;
        prog_cnt_q <= '0;
      end
    end else begin
      if (prog_idx_q < 4'h5) begin
        prog_idx_q <= prog_idx_q + 1'b1;
      end
      if (prog_cnt_q >= (`CNT_W+5)'(`NVM_PROG_CYCLES)) begin
        nvm_busy <= 1'b0;
        nvm_ready <= 1'b1;
      end else begin
        prog_cnt_q <= prog_cnt_q + 1'b1;
      end
    end
  end

  // Startup load and register writes
  always_ff @(posedge clk) begin
    if (off_req || mode_q == led_mode_pkg::MODE_SHUTDOWN) begin
      load_idx_q <= 4'h0;
      load_done_q <= 1'b0;
      iset <= '0;
      soft_start_sel <= '0;
      timeout_sel <= '0;
    end else if (mode_q == led_mode_pkg::MODE_STARTUP) begin
      if (!load_done_q) begin
        load_idx_q <= load_idx_q + 1'b1;
        case (load_idx_q)
          4'h1: iset.red <= nvm_rdata;
          4'h2: iset.green <= nvm_rdata;
          4'h3: iset.blue <= nvm_rdata;
          4'h4: soft_start_sel <= nvm_rdata[`SS_SEL_W-1:0];
          4'h5: begin
            timeout_sel <= nvm_rdata[`TO_SEL_W-1:0];
            load_done_q <= 1'b1;
          end
          default: ;
        endcase
      end
    end else if (cfg_we && !nvm_busy) begin
      iset <= cfg_iset;
      soft_start_sel <= cfg_soft_start;
      timeout_sel <= cfg_timeout;
    end
  end

  // ----------------------------------------
  // Registered outputs
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (off_req) begin
      mode <= led_mode_pkg::MODE_SHUTDOWN;
      support_on <= 1'b0;
      converter_on <= 1'b0;
      converter_low_current <= 1'b0;
      driver_on <= '0;
    end else begin
      mode <= mode_q;
      support_on <= mode_q != led_mode_pkg::MODE_SHUTDOWN;
      converter_on <= mode_q == led_mode_pkg::MODE_SOFT_START ||
                      mode_q == led_mode_pkg::MODE_NORMAL;
      converter_low_current <= mode_q == led_mode_pkg::MODE_SOFT_START;
      driver_on.red <= chan_q == led_mode_pkg::CH_RED;
      driver_on.green <= chan_q == led_mode_pkg::CH_GREEN;
      driver_on.blue <= chan_q == led_mode_pkg::CH_BLUE;
    end
  end

endmodule
